/* src/ais_input_select.sv */
// file: audio input source selector, slot mapping and converter skip decision
// Notes on behaviour
// - route exactly one of three sources
// - serial input gives at most four channels
// - serial master fixes 48 kHz, skip bit obeyed
// - serial slave 32-96 kHz, converter always used
// - serial chosen when strap low, select 0
// - spdif 32-96 kHz, converter always used
// - receiver style bit picks analog or digital
// - spdif chosen when strap low, select 1
// - strap high picks link, select ignored
// - role strap picks primary or secondary codec
// - 48/44.1 kHz slot to channel mapping
// - high rates use 3,4,6, then 10-12 when needed
// - six-channel link at 48 kHz always skips
// - centre only from link at 48 kHz or high rates, lfe only from six-channel link
// - core stream fixed at 48 kHz unless skipped
`timescale 1ns/1ns
module ais_input_select
	import ais_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                resetn,
	input  wire logic                linkClock,
	input  wire logic                linkResetn,
	input  wire logic                linkSourceStrap,
	input  wire logic                linkRoleStrap,
	input  wire logic                serialSpdifSelect,
	input  wire logic                rateConverterSkip,
	input  wire logic                serialMaster,
	input  wire logic                receiverDigital,
	input  wire logic [1:0]          linkRate,
	input  wire logic                linkHighRateNeed,
	input  wire logic                serialValid,
	input  wire logic [1:0]          serialChannel,
	input  wire logic [SAMPLE_W-1:0] serialData,
	input  wire logic                spdifValid,
	input  wire logic                spdifRight,
	input  wire logic [SAMPLE_W-1:0] spdifData,
	input  wire logic                linkSlotValid,
	input  wire logic [3:0]          linkSlot,
	input  wire logic [SAMPLE_W-1:0] linkSlotData,
	input  wire logic                linkFrameEnd,
	output      logic [2:0]          activeSource,
	output      logic                converterInPath,
	output      logic                receiverAnalogEn,
	output      logic                linkSecondary,
	output      logic [12:0]         linkSlotRequest,
	output      logic                coreValid,
	output      logic [SAMPLE_W-1:0] coreLeft,
	output      logic [SAMPLE_W-1:0] coreRight,
	output      logic [SAMPLE_W-1:0] coreCenter,
	output      logic [SAMPLE_W-1:0] coreSurL,
	output      logic [SAMPLE_W-1:0] coreSurR,
	output      logic [SAMPLE_W-1:0] coreLfe,
	output      logic                coreNextValid,
	output      logic [SAMPLE_W-1:0] coreNextLeft,
	output      logic [SAMPLE_W-1:0] coreNextRight,
	output      logic [SAMPLE_W-1:0] coreNextCenter
);

	////////////////////////////////////////////////////////////////////////////
	// synchronised straps and configuration levels

	localparam int CFG_W = 9;

	logic [CFG_W-1:0] cfgRaw;
	logic [CFG_W-1:0] cfgSync;
	logic             sSrcStrap;
	logic             sRole;
	logic             sSel;
	logic             sSkip;
	logic             sMaster;
	logic             sDigital;
	logic [1:0]       sRate;
	logic             sNeed;

	assign cfgRaw = {linkSourceStrap, linkRoleStrap, serialSpdifSelect, rateConverterSkip,
		serialMaster, receiverDigital, linkRate, linkHighRateNeed};

	ais_sync #(
		.W (CFG_W)
	) u_cfgSync (
		.clock  (clock),
		.resetn (resetn),
		.din    (cfgRaw),
		.dout   (cfgSync)
	);

	assign {sSrcStrap, sRole, sSel, sSkip, sMaster, sDigital, sRate, sNeed} = cfgSync;

	////////////////////////////////////////////////////////////////////////////
	// link slots cross from the link clock as whole words

	localparam int LW = 4 + SAMPLE_W + 2;

	logic          lkValid;
	logic [LW-1:0] lkWord;
	logic          lkSlotOk;
	logic [3:0]    lkSlot;
	logic [SAMPLE_W-1:0] lkData;
	logic          lkEnd;

	// slot valid rides along: a bare frame end must never write stale slot data
	ais_link_cdc #(
		.W (LW)
	) u_linkCdc (
		.linkClock  (linkClock),
		.linkResetn (linkResetn),
		.srcValid   (linkSlotValid | linkFrameEnd),
		.srcData    ({linkSlotValid, linkSlot, linkSlotData, linkFrameEnd}),
		.clock      (clock),
		.resetn     (resetn),
		.dstValid   (lkValid),
		.dstData    (lkWord)
	);

	assign {lkSlotOk, lkSlot, lkData, lkEnd} = lkWord;

	////////////////////////////////////////////////////////////////////////////
	// serial and spdif pins pass two flops together with their valid levels

	logic [1:0]            strobeSync;
	logic [1:0]            strobePrev;
	logic                  serStrobe;
	logic                  spdStrobe;
	logic [2*SAMPLE_W+4:0] pinSync;
	logic [1:0]            sChannel;
	logic                  sRight;
	logic [SAMPLE_W-1:0]   sSerData;
	logic [SAMPLE_W-1:0]   sSpdData;

	ais_sync #(
		.W (2*SAMPLE_W + 5)
	) u_strobeSync (
		.clock  (clock),
		.resetn (resetn),
		.din    ({serialValid, spdifValid, serialChannel, spdifRight, serialData, spdifData}),
		.dout   (pinSync)
	);
	assign {strobeSync, sChannel, sRight, sSerData, sSpdData} = pinSync;

	// sources hold data stable around their valid level, so edge after sync is safe
	assign serStrobe = strobeSync[1] & ~strobePrev[1];
	assign spdStrobe = strobeSync[0] & ~strobePrev[0];

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [1:0]                 strobePrev;
		ais_src_e                   src;
		logic                       inPath;
		logic                       analogEn;
		logic                       secondary;
		logic [12:0]                slotReq;
		logic [NUM_CH-1:0][SAMPLE_W-1:0] acc;
		logic [2:0][SAMPLE_W-1:0]   accNext;
		logic                       valid;
		logic [NUM_CH-1:0][SAMPLE_W-1:0] out;
		logic                       nextValid;
		logic [2:0][SAMPLE_W-1:0]   outNext;
	} ais_state_s;

	ais_state_s st;
	ais_state_s next_st;

	assign strobePrev = st.strobePrev;

	always_comb begin
		next_st            = st;
		next_st.strobePrev = strobeSync;
		next_st.valid      = 1'b0;
		next_st.nextValid  = 1'b0;

		if (sSrcStrap) begin
			next_st.src = AIS_SRC_LINK;
		end else if (sSel) begin
			next_st.src = AIS_SRC_SPDIF;
		end else begin
			next_st.src = AIS_SRC_SERIAL;
		end

		case (st.src)
			AIS_SRC_SERIAL: begin
				next_st.inPath = !(sMaster && sSkip);
			end
			AIS_SRC_SPDIF: begin
				next_st.inPath = 1'b1;
			end
			AIS_SRC_LINK: begin
				next_st.inPath = (sRate != RATE_48);
			end
			default: begin
				next_st.inPath = 1'b1;
			end
		endcase

		next_st.analogEn  = !sDigital;
		next_st.secondary = sRole;

		next_st.slotReq = '0;
		if (st.src == AIS_SRC_LINK) begin
			next_st.slotReq[SLOT_LEFT]  = 1'b1;
			next_st.slotReq[SLOT_RIGHT] = 1'b1;
			case (sRate)
				RATE_48: begin
					next_st.slotReq[SLOT_CTR]  = 1'b1;
					next_st.slotReq[SLOT_SURL] = 1'b1;
					next_st.slotReq[SLOT_SURR] = 1'b1;
					next_st.slotReq[SLOT_LFE]  = 1'b1;
				end
				RATE_44: begin
					next_st.slotReq[SLOT_SURL] = 1'b1;
					next_st.slotReq[SLOT_SURR] = 1'b1;
				end
				default: begin
					next_st.slotReq[SLOT_CTR]    = 1'b1;
					next_st.slotReq[SLOT_LEFT2]  = sNeed;
					next_st.slotReq[SLOT_RIGHT2] = sNeed;
					next_st.slotReq[SLOT_CTR2]   = sNeed;
				end
			endcase
		end

		// a source change discards any half-gathered frame
		if (next_st.src != st.src) begin
			next_st.acc     = '0;
			next_st.accNext = '0;
		end else begin
			case (st.src)
				AIS_SRC_SERIAL: begin
					if (serStrobe) begin
						// only four channels exist on the serial input
						case (sChannel)
							2'h0: next_st.acc[CH_LEFT]  = sSerData;
							2'h1: next_st.acc[CH_RIGHT] = sSerData;
							2'h2: next_st.acc[CH_SURL]  = sSerData;
							default: begin
								next_st.acc[CH_SURR] = sSerData;
								next_st.valid        = 1'b1;
							end
						endcase
						next_st.acc[CH_CTR] = '0;
						next_st.acc[CH_LFE] = '0;
					end
				end
				AIS_SRC_SPDIF: begin
					if (spdStrobe) begin
						if (sRight) begin
							next_st.acc[CH_RIGHT] = sSpdData;
							next_st.valid         = 1'b1;
						end else begin
							next_st.acc[CH_LEFT] = sSpdData;
						end
						next_st.acc[CH_CTR]  = '0;
						next_st.acc[CH_SURL] = '0;
						next_st.acc[CH_SURR] = '0;
						next_st.acc[CH_LFE]  = '0;
					end
				end
				AIS_SRC_LINK: begin
					if (lkValid) begin
						if (lkSlotOk && lkSlot <= SLOT_CTR2 && st.slotReq[lkSlot]) begin
							case (lkSlot)
								SLOT_LEFT:   next_st.acc[CH_LEFT]     = lkData;
								SLOT_RIGHT:  next_st.acc[CH_RIGHT]    = lkData;
								SLOT_CTR:    next_st.acc[CH_CTR]      = lkData;
								SLOT_SURL:   next_st.acc[CH_SURL]     = lkData;
								SLOT_SURR:   next_st.acc[CH_SURR]     = lkData;
								SLOT_LFE:    next_st.acc[CH_LFE]      = lkData;
								SLOT_LEFT2:  next_st.accNext[CH_LEFT]  = lkData;
								SLOT_RIGHT2: next_st.accNext[CH_RIGHT] = lkData;
								SLOT_CTR2:   next_st.accNext[CH_CTR]   = lkData;
								default: begin
								end
							endcase
						end
						if (lkEnd) begin
							next_st.valid     = 1'b1;
							next_st.nextValid = st.slotReq[SLOT_LEFT2];
							if (!st.slotReq[SLOT_CTR]) begin
								next_st.acc[CH_CTR] = '0;
							end
							if (!st.slotReq[SLOT_LFE]) begin
								next_st.acc[CH_LFE] = '0;
							end
							if (!st.slotReq[SLOT_SURL]) begin
								next_st.acc[CH_SURL] = '0;
								next_st.acc[CH_SURR] = '0;
							end
						end
					end
				end
				default: begin
					next_st.acc = '0;
				end
			endcase
		end

		// only the selected source reaches the core
		if (next_st.valid) begin
			next_st.out = next_st.acc;
		end
		if (next_st.nextValid) begin
			next_st.outNext = next_st.accNext;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st          <= '0;
			st.src      <= AIS_SRC_SERIAL;
			st.inPath   <= 1'b1;
			st.analogEn <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign activeSource     = st.src;
	assign converterInPath  = st.inPath;
	assign receiverAnalogEn = st.analogEn;
	assign linkSecondary    = st.secondary;
	assign linkSlotRequest  = st.slotReq;
	assign coreValid        = st.valid;
	assign coreLeft         = st.out[CH_LEFT];
	assign coreRight        = st.out[CH_RIGHT];
	assign coreCenter       = st.out[CH_CTR];
	assign coreSurL         = st.out[CH_SURL];
	assign coreSurR         = st.out[CH_SURR];
	assign coreLfe          = st.out[CH_LFE];
	assign coreNextValid    = st.nextValid;
	assign coreNextLeft     = st.outNext[CH_LEFT];
	assign coreNextRight    = st.outNext[CH_RIGHT];
	assign coreNextCenter   = st.outNext[CH_CTR];

endmodule : ais_input_select

/* src/ais_pkg.sv */
// package: constants and types for the audio input source selector
package ais_pkg;

	localparam int SAMPLE_W = 24;
	localparam int NUM_CH   = 6;

	// processing channel indices
	localparam int CH_LEFT  = 0;
	localparam int CH_RIGHT = 1;
	localparam int CH_CTR   = 2;
	localparam int CH_SURL  = 3;
	localparam int CH_SURR  = 4;
	localparam int CH_LFE   = 5;

	// link slot numbers
	localparam logic [3:0] SLOT_LEFT   = 4'h3;
	localparam logic [3:0] SLOT_RIGHT  = 4'h4;
	localparam logic [3:0] SLOT_CTR    = 4'h6;
	localparam logic [3:0] SLOT_SURL   = 4'h7;
	localparam logic [3:0] SLOT_SURR   = 4'h8;
	localparam logic [3:0] SLOT_LFE    = 4'h9;
	localparam logic [3:0] SLOT_LEFT2  = 4'hA;
	localparam logic [3:0] SLOT_RIGHT2 = 4'hB;
	localparam logic [3:0] SLOT_CTR2   = 4'hC;

	// link sample rate codes
	localparam logic [1:0] RATE_48  = 2'h0;
	localparam logic [1:0] RATE_44  = 2'h1;
	localparam logic [1:0] RATE_88  = 2'h2;
	localparam logic [1:0] RATE_96  = 2'h3;

	// serial input rate limits and core rate in hz
	localparam int SER_MASTER_HZ = 48000;
	localparam int RATE_MIN_HZ   = 32000;
	localparam int RATE_MAX_HZ   = 96000;
	localparam int CORE_RATE_HZ  = 48000;

	typedef enum logic [2:0] {
		AIS_SRC_SERIAL = 3'h1,
		AIS_SRC_SPDIF  = 3'h2,
		AIS_SRC_LINK   = 3'h4
	} ais_src_e;

	typedef logic [SAMPLE_W-1:0] ais_sample_t;

endpackage : ais_pkg

/* src/ais_sync.sv */
// file: two flip-flop level synchroniser
`timescale 1ns/1ns
module ais_sync
	import ais_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output      logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} ais_sync_s;

	ais_sync_s st;
	ais_sync_s next_st;

	always_comb begin
		next_st.meta   = din;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.stable;
endmodule : ais_sync

/* src/ais_link_cdc.sv */
// file: word handshake from link clock domain into processing domain
`timescale 1ns/1ns
module ais_link_cdc
	import ais_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         linkClock,
	input  wire logic         linkResetn,
	input  wire logic         srcValid,
	input  wire logic [W-1:0] srcData,
	input  wire logic         clock,
	input  wire logic         resetn,
	output      logic         dstValid,
	output      logic [W-1:0] dstData
);
	// source side: capture word, flip toggle; words arriving while busy are dropped
	typedef struct packed {
		logic         req;
		logic [W-1:0] hold;
		logic [1:0]   ackSync;
	} ais_cdcs_s;
	typedef struct packed {
		logic [1:0]   reqSync;
		logic         reqSeen;
		logic         valid;
		logic [W-1:0] data;
	} ais_cdcd_s;

	ais_cdcs_s s;
	ais_cdcs_s next_s;
	ais_cdcd_s d;
	ais_cdcd_s next_d;
	logic      idle;

	always_comb begin
		next_s         = s;
		next_s.ackSync = {s.ackSync[0], d.reqSeen};
		idle           = (s.req == s.ackSync[1]);
		if (srcValid && idle) begin
			next_s.hold = srcData;
			next_s.req  = ~s.req;
		end
	end

	always_ff @(posedge linkClock or negedge linkResetn) begin
		if (!linkResetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		next_d         = d;
		next_d.reqSync = {d.reqSync[0], s.req};
		next_d.valid   = 1'b0;
		if (d.reqSync[1] != d.reqSeen) begin
			next_d.reqSeen = d.reqSync[1];
			next_d.data    = s.hold;
			next_d.valid   = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			d <= '0;
		end else begin
			d <= next_d;
		end
	end

	assign dstValid = d.valid;
	assign dstData  = d.data;
endmodule : ais_link_cdc

/* dv/ais_input_select_props.sv */
// checker: source selection, converter path and channel rules
`timescale 1ns/1ns
module ais_input_select_props
	import ais_pkg::*;
(
	input wire logic                clock,
	input wire logic                resetn,
	input wire logic                linkSourceStrap,
	input wire logic                linkRoleStrap,
	input wire logic                serialSpdifSelect,
	input wire logic                rateConverterSkip,
	input wire logic                serialMaster,
	input wire logic                receiverDigital,
	input wire logic [1:0]          linkRate,
	input wire logic                linkHighRateNeed,
	input wire logic [2:0]          activeSource,
	input wire logic                converterInPath,
	input wire logic                receiverAnalogEn,
	input wire logic                linkSecondary,
	input wire logic [12:0]         linkSlotRequest,
	input wire logic                coreValid,
	input wire logic [SAMPLE_W-1:0] coreCenter,
	input wire logic [SAMPLE_W-1:0] coreLfe
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// six cycles cover the 2-ff sync plus the registered answer
	property p_one_src; $onehot(activeSource); endproperty
	property p_link_sel; linkSourceStrap[*6] |-> activeSource == 3'h4; endproperty
	property p_ser_sel; (!linkSourceStrap && !serialSpdifSelect)[*6] |-> activeSource == 3'h1;
	endproperty
	property p_spd_sel; (!linkSourceStrap && serialSpdifSelect)[*6] |-> activeSource == 3'h2;
	endproperty
	property p_role; $stable(linkRoleStrap)[*6] |-> linkSecondary == linkRoleStrap; endproperty
	property p_style; $stable(receiverDigital)[*6] |-> receiverAnalogEn != receiverDigital;
	endproperty
	property p_mskip;
		(activeSource == 3'h1 && serialMaster && rateConverterSkip)[*6] |-> !converterInPath;
	endproperty
	property p_slave; (activeSource == 3'h1 && !serialMaster)[*6] |-> converterInPath;
	endproperty
	property p_spd_conv; (activeSource == 3'h2)[*3] |-> converterInPath; endproperty
	property p_l48; (activeSource == 3'h4 && linkRate == RATE_48)[*6] |-> !converterInPath;
	endproperty
	property p_hi;
		(activeSource == 3'h4 && linkRate[1] && $stable(linkHighRateNeed))[*6]
		|-> linkSlotRequest[12:10] == {3{linkHighRateNeed}} && linkSlotRequest[6:3] == 4'hB;
	endproperty
	property p_no_ctr;
		coreValid && activeSource != 3'h4 |-> coreCenter == '0 && coreLfe == '0;
	endproperty
	a_one_src: assert property (p_one_src) else $error("source not one-hot");
	a_link_sel: assert property (p_link_sel) else $error("link not chosen");
	a_ser_sel: assert property (p_ser_sel) else $error("serial not chosen");
	a_spd_sel: assert property (p_spd_sel) else $error("spdif not chosen");
	a_role: assert property (p_role) else $error("codec role wrong");
	a_style: assert property (p_style) else $error("receiver style wrong");
	a_mskip: assert property (p_mskip) else $error("master skip ignored");
	a_slave: assert property (p_slave) else $error("slave skipped converter");
	a_spd_conv: assert property (p_spd_conv) else $error("spdif skipped converter");
	a_l48: assert property (p_l48) else $error("link 48k not skipped");
	a_hi: assert property (p_hi) else $error("high rate slots wrong");
	a_no_ctr: assert property (p_no_ctr) else $error("centre or lfe not zero");
	c_ser: cover property (coreValid && activeSource == 3'h1);
	c_spd: cover property (coreValid && activeSource == 3'h2);
	c_link: cover property (coreValid && activeSource == 3'h4);
endmodule : ais_input_select_props
bind ais_input_select ais_input_select_props i_ais_input_select_props (.*);

/* dv/ais_link_source.sv */
// partner: link controller model sending slot words and frame ends
`timescale 1ns/1ns
module ais_link_source
	import ais_pkg::*;
(
	output logic                linkClock,
	output logic                linkSlotValid,
	output logic [3:0]          linkSlot,
	output logic [SAMPLE_W-1:0] linkSlotData,
	output logic                linkFrameEnd
);
	initial begin
		linkClock = 1'b0;
		linkSlotValid = 1'b0;
		linkSlot = 4'h0;
		linkSlotData = '0;
		linkFrameEnd = 1'b0;
	end
	// clock runs only while the model has something to send
	task tick(input int n);
		repeat (n) begin
			#32 linkClock = 1'b1;
			#32 linkClock = 1'b0;
			// released lines never keep their last value
			linkSlot = ~linkSlot;
			linkSlotData = ~linkSlotData;
		end
	endtask : tick
	// words spaced 9 link clocks so the crossing is always idle
	task send_frame(input logic [12:0] mask, input logic [SAMPLE_W-1:0] base);
		for (int s = 3; s < 13; s++) begin
			if (mask[s]) begin
				linkSlotValid = 1'b1;
				linkSlot = 4'(s);
				linkSlotData = base + SAMPLE_W'(s);
				tick(1);
				linkSlotValid = 1'b0;
				tick(8);
			end
		end
		linkFrameEnd = 1'b1;
		tick(1);
		linkFrameEnd = 1'b0;
		tick(8);
	endtask : send_frame
endmodule : ais_link_source

/* dv/test_ais_input_select.sv */
// testbench: source selection, channel mapping and converter decisions
`timescale 1ns/1ns
module test_ais_input_select
	import ais_pkg::*;
;
	logic                clock, resetn, linkResetn, linkClock;
	logic                linkSourceStrap, linkRoleStrap, serialSpdifSelect, rateConverterSkip;
	logic                serialMaster, receiverDigital, linkHighRateNeed;
	logic [1:0]          linkRate, serialChannel;
	logic                serialValid, spdifValid, spdifRight, linkSlotValid, linkFrameEnd;
	logic [3:0]          linkSlot;
	logic [SAMPLE_W-1:0] serialData, spdifData, linkSlotData;
	logic [2:0]          activeSource;
	logic                converterInPath, receiverAnalogEn, linkSecondary, coreValid;
	logic [12:0]         linkSlotRequest;
	logic [SAMPLE_W-1:0] coreLeft, coreRight, coreCenter, coreSurL, coreSurR, coreLfe;
	logic                coreNextValid;
	logic [SAMPLE_W-1:0] coreNextLeft, coreNextRight, coreNextCenter;
	int                  num_errors = 0;
	int                  check_count = 0;
	ais_input_select i_ais_input_select (.*);
	ais_link_source i_ais_link_source (.*);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task give_verdict;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task check_core(input logic [23:0] l, r, c, sl, sr, lf);
		check(coreLeft, l);
		check(coreRight, r);
		check(coreCenter, c);
		check(coreSurL, sl);
		check(coreSurR, sr);
		check(coreLfe, lf);
	endtask : check_core
	task settle;
		repeat (8) @(negedge clock);
	endtask : settle
	task wait_core(input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (coreValid !== 1'b1 && n < lim);
		if (coreValid !== 1'b1) begin
			check(32'h0, 32'h1);
			give_verdict();
		end
	endtask : wait_core
	// both inputs carry a sample; only the selected one may land
	task send_sample(input logic [1:0] ch, input logic [23:0] d);
		@(negedge clock);
		serialChannel = ch;
		serialData = d;
		spdifRight = ch[0];
		spdifData = ~d;
		serialValid = 1'b1;
		spdifValid = 1'b1;
		repeat (5) @(negedge clock);
		serialValid = 1'b0;
		spdifValid = 1'b0;
		repeat (4) @(negedge clock);
	endtask : send_sample
	task link_frame(input logic [23:0] base, input logic nxt);
		fork
			i_ais_link_source.send_frame(13'h1FF8, base);
			begin
				wait_core(2000);
				check({31'h0, coreNextValid}, {31'h0, nxt});
			end
		join
	endtask : link_frame
	////////////////////////////////////////////////////////////////////////////////
	task t_serial;
		serialMaster = 1'b1;
		rateConverterSkip = 1'b1;
		settle();
		check(activeSource, 32'h1);
		check(converterInPath, 32'h0);
		fork
			for (int i = 0; i < 4; i++) send_sample(2'(i), 24'hA00000 + 24'(i));
			wait_core(100);
		join
		check_core(24'hA00000, 24'hA00001, 24'h0, 24'hA00002, 24'hA00003, 24'h0);
		rateConverterSkip = 1'b0;
		settle();
		check(converterInPath, 32'h1);
		rateConverterSkip = 1'b1;
		serialMaster = 1'b0;
		settle();
		check(converterInPath, 32'h1);
		$display("serial test done");
	endtask : t_serial
	task t_spdif;
		serialSpdifSelect = 1'b1;
		receiverDigital = 1'b1;
		settle();
		check(activeSource, 32'h2);
		check(converterInPath, 32'h1);
		check(receiverAnalogEn, 32'h0);
		fork
			begin
				send_sample(2'h0, 24'hB00000);
				send_sample(2'h1, 24'hB00001);
			end
			wait_core(60);
		join
		check_core(~24'hB00000, ~24'hB00001, 24'h0, 24'h0, 24'h0, 24'h0);
		receiverDigital = 1'b0;
		settle();
		check(receiverAnalogEn, 32'h1);
		$display("spdif test done");
	endtask : t_spdif
	task t_link;
		linkSourceStrap = 1'b1;
		linkRoleStrap = 1'b1;
		rateConverterSkip = 1'b0;
		settle();
		check(activeSource, 32'h4);
		check(linkSecondary, 32'h1);
		check(converterInPath, 32'h0);
		check(linkSlotRequest, 32'h3D8);
		link_frame(24'hC00000, 1'b0);
		check_core(24'hC00003, 24'hC00004, 24'hC00006, 24'hC00007, 24'hC00008, 24'hC00009);
		linkRate = RATE_44;
		linkRoleStrap = 1'b0;
		settle();
		check(linkSecondary, 32'h0);
		check(converterInPath, 32'h1);
		check(linkSlotRequest, 32'h198);
		link_frame(24'hD00000, 1'b0);
		check_core(24'hD00003, 24'hD00004, 24'h0, 24'hD00007, 24'hD00008, 24'h0);
		$display("link test done");
	endtask : t_link
	task t_link_high;
		logic [23:0] base;
		for (int i = 2; i < 4; i++) begin
			base = {4'hE, 4'(i), 16'h0};
			linkRate = 2'(i);
			linkHighRateNeed = 1'b1;
			settle();
			check(linkSlotRequest, 32'h1C58);
			check(converterInPath, 32'h1);
			link_frame(base, 1'b1);
			check_core(base + 24'h3, base + 24'h4, base + 24'h6, 24'h0, 24'h0, 24'h0);
			check(coreNextLeft, {8'h0, base + 24'hA});
			check(coreNextRight, {8'h0, base + 24'hB});
			check(coreNextCenter, {8'h0, base + 24'hC});
			linkHighRateNeed = 1'b0;
			settle();
			check(linkSlotRequest, 32'h58);
		end
		$display("high rate link test done");
	endtask : t_link_high
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, linkResetn, linkSourceStrap, linkRoleStrap, serialSpdifSelect} = '0;
		{rateConverterSkip, serialMaster, receiverDigital, linkHighRateNeed} = '0;
		{linkRate, serialChannel, serialValid, spdifValid, spdifRight} = '0;
		serialData = '0;
		spdifData = '0;
		repeat (5) @(negedge clock);
		check(activeSource, 32'h1);
		check(coreValid, 32'h0);
		resetn = 1'b1;
		i_ais_link_source.tick(2);
		linkResetn = 1'b1;
		repeat (5) @(negedge clock);
		t_serial();
		t_spdif();
		t_link();
		t_link_high();
		give_verdict();
	end
endmodule : test_ais_input_select
